/* inc/frontend_consts.svh */
// Purpose: Offsets, field positions, reset values and counts for the front end control.
// Assumes: Word-wide register port with a 4-bit register address.
// Notes: Definitions only.
`ifndef FRONTEND_CONSTS_SVH
`define FRONTEND_CONSTS_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define PRI_CTRL_ADDR 4'h0
`define AUX_CTRL_ADDR 4'h1
`define CUR_CTRL_ADDR 4'h2
`define STATUS_ADDR 4'h3
`define PRI_RESULT_ADDR 4'h4
`define AUX_RESULT_ADDR 4'h5

// ************************************************************
// Field positions
// ************************************************************
`define PRI_CH_LSB 0
`define PRI_CH_MSB 1
`define PRI_RANGE_LSB 2
`define PRI_RANGE_MSB 4
`define PRI_UNI_BIT 5
`define AUX_CH_LSB 0
`define AUX_CH_MSB 1
`define AUX_UNI_BIT 2
`define CUR_BURN_BIT 0
`define CUR_A_LSB 1
`define CUR_A_MSB 2
`define CUR_B_LSB 3
`define CUR_B_MSB 4
`define ST_PRI_SETTLING_BIT 0
`define ST_AUX_SETTLING_BIT 1
`define ST_PRI_READY_BIT 2
`define ST_AUX_READY_BIT 3

// ************************************************************
// Reset values and counts
// ************************************************************
`define PRI_CTRL_RST 6'h00
`define AUX_CTRL_RST 3'h0
`define CUR_CTRL_RST 5'h00
`define SETTLE_PERIODS 2

`endif

/* inc/frontend_pkg.sv */
// Purpose: Types shared by the front end control modules.
// Assumes: Encodings follow declaration order.
// Notes: Constants live in frontend_consts.svh.
package frontend_pkg;

	// Primary differential pair selection
	typedef enum logic [1:0] {pair_1_2, pair_3_4, pair_3_2, pair_2_2_short} pri_channel_type;

	// Auxiliary single-ended source selection
	typedef enum logic [1:0] {aux_input_3, aux_input_4, aux_input_5, aux_temp_sensor} aux_channel_type;

	// Primary gain ranges, 20 mV up to 2.56 V span with a 2.5 V reference
	typedef enum logic [2:0] {range_20mv, range_40mv, range_80mv, range_160mv,
		range_320mv, range_640mv, range_1280mv, range_2560mv} gain_range_type;

	// Steering of one 200 uA excitation source
	typedef enum logic [1:0] {route_off, route_pin1, route_pin2, route_spare} exc_route_type;

	// Register state of the top module
	typedef struct packed {
		pri_channel_type pri_channel;
		gain_range_type pri_range;
		logic pri_unipolar;
		aux_channel_type aux_channel;
		logic aux_unipolar;
		logic burnout;
		exc_route_type route_a;
		exc_route_type route_b;
		logic pri_restart;
		logic aux_restart;
		logic pri_ready;
		logic aux_ready;
		logic [31:0] rdata;
	} frontend_state_type;

endpackage

/* verilog/current_switch_decoder.sv */
// Purpose: Turns burnout and excitation settings into registered switch enables.
// Assumes: Settings come from registers of the control block.
// Notes: Spare route code leaves a source off.
`timescale 1ns/1ps
module current_switch_decoder (
	input wire logic clk,
	input wire logic reset,
	input wire logic burnout,
	input wire frontend_pkg::exc_route_type route_a,
	input wire frontend_pkg::exc_route_type route_b,
	output logic burn_src_on,
	output logic burn_snk_on,
	output logic pin1_from_a,
	output logic pin1_from_b,
	output logic pin2_from_a,
	output logic pin2_from_b
);
	// Switch state
	typedef struct packed {
		logic burn_src;
		logic burn_snk;
		logic [1:0] pin1;
		logic [1:0] pin2;
	} switch_state_type;

	switch_state_type state_r;
	switch_state_type state_nxt;

	// ************************************************************
	// Decode
	// ************************************************************
	// Both burnout currents follow one bit; both sources may land on one pin
	always_comb begin
		state_nxt.burn_src = burnout; // RULE_10
		state_nxt.burn_snk = burnout; // RULE_10
		state_nxt.pin1 = {route_b == frontend_pkg::route_pin1,
			route_a == frontend_pkg::route_pin1}; // RULE_13
		state_nxt.pin2 = {route_b == frontend_pkg::route_pin2,
			route_a == frontend_pkg::route_pin2}; // RULE_13
	end

	// Register the enables, all off at reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign burn_src_on = state_r.burn_src;
	assign burn_snk_on = state_r.burn_snk;
	assign pin1_from_a = state_r.pin1[0];
	assign pin1_from_b = state_r.pin1[1];
	assign pin2_from_a = state_r.pin2[0];
	assign pin2_from_b = state_r.pin2[1];
endmodule

/* verilog/result_chop_coder.sv */
// Purpose: Averages filter outputs, holds off results while settling, applies coding.
// Assumes: Samples are two's complement fractions of full scale.
// Notes: Restart discards history.
`timescale 1ns/1ps
`include "frontend_consts.svh"
module result_chop_coder #(
	parameter int WIDTH = 24,
	parameter int SETTLE = `SETTLE_PERIODS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic restart,
	input wire logic unipolar,
	input wire logic sample_strobe,
	input wire logic [WIDTH-1:0] sample,
	output logic [WIDTH-1:0] result,
	output logic result_strobe,
	output logic settling
);
	// Path state
	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic [1:0] seen;
		logic [WIDTH-1:0] result;
		logic strobe;
		logic settling;
	} path_state_type;

	path_state_type state_r;
	path_state_type state_nxt;
	logic [WIDTH:0] sum; // Widened sum of two samples

	// Output coding over the full word
	function automatic logic [WIDTH-1:0] code(input logic [WIDTH-1:0] v, input logic uni);
		logic [WIDTH-1:0] c;
		c = {~v[WIDTH-1], v[WIDTH-2:0]}; // RULE_09
		if (uni) begin
			if (v[WIDTH-1]) begin
				c = '0; // RULE_08
			end else if (&v[WIDTH-2:0]) begin
				c = '1; // RULE_08
			end else begin
				c = {v[WIDTH-2:0], 1'b0}; // RULE_08
			end
		end
		return c; // RULE_15
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.strobe = 1'b0;
		sum = {state_r.prev[WIDTH-1], state_r.prev} + {sample[WIDTH-1], sample};
		if (restart) begin
			// New channel: forget history, wait again
			state_nxt.seen = 2'h0; // RULE_03
			state_nxt.settling = 1'b1;
		end else if (sample_strobe) begin
			state_nxt.prev = sample;
			if (state_r.seen < 2'(SETTLE - 1)) begin
				state_nxt.seen = state_r.seen + 2'h1; // RULE_04
			end else begin
				// Chop average of this and previous output
				state_nxt.result = code(sum[WIDTH:1], unipolar); // RULE_07
				state_nxt.strobe = 1'b1; // RULE_04
				state_nxt.settling = 1'b0;
			end
		end
	end

	// Register, settling after reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= '{prev: '0, seen: 2'h0, result: '0, strobe: 1'b0, settling: 1'b1};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign result = state_r.result;
	assign result_strobe = state_r.strobe;
	assign settling = state_r.settling;
endmodule

/* verilog/adc_input_frontend_control.sv */
// Purpose: Control of the analog front end of a two-converter measurement unit.
// Assumes: Filter output words arrive as two's complement with a one-cycle strobe.
// Notes: Registers sit on a plain word port with read data one cycle later.
//
// Operation
// RULE_01: Primary selects three pairs or shorted input
// RULE_02: Auxiliary selects inputs 3, 4, 5 or temperature
// RULE_03: Channel change withholds results until settled
// RULE_04: Settling takes two output update periods
// RULE_05: Primary range picks one of eight gains
// RULE_06: Auxiliary has one fixed span, no gain
// RULE_07: Polarity bit changes output coding only
// RULE_08: Unipolar results use straight binary
// RULE_09: Bipolar results use offset binary
// RULE_10: One bit switches both burnout currents
// RULE_11: Software clears burnout for normal measurement
// RULE_12: Software reads full-scale open, zero shorted
// RULE_13: Two excitation sources, separate or one pin
// RULE_14: Field encodings and positions are parameters
// RULE_15: Result width per converter, coding full width
`timescale 1ns/1ps
`include "frontend_consts.svh"

module adc_input_frontend_control #(
	parameter int PRI_WIDTH = 24,
	parameter int AUX_WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Filter outputs
	input wire logic pri_sample_strobe,
	input wire logic [PRI_WIDTH-1:0] pri_sample,
	input wire logic aux_sample_strobe,
	input wire logic [AUX_WIDTH-1:0] aux_sample,
	// Analog switch controls
	output frontend_pkg::pri_channel_type pri_channel_sel,
	output frontend_pkg::gain_range_type pri_range_sel,
	output logic pri_unipolar,
	output frontend_pkg::aux_channel_type aux_channel_sel,
	output logic aux_unipolar,
	output logic burnout_source_on,
	output logic burnout_sink_on,
	output logic excitation_pin_1_from_a,
	output logic excitation_pin_1_from_b,
	output logic excitation_pin_2_from_a,
	output logic excitation_pin_2_from_b,
	// Coded results
	output logic [PRI_WIDTH-1:0] pri_result,
	output logic pri_result_strobe,
	output logic pri_settling,
	output logic [AUX_WIDTH-1:0] aux_result,
	output logic aux_result_strobe,
	output logic aux_settling
);

	// ************************************************************
	// Declarations
	// ************************************************************

	// Whole register state of this module
	frontend_pkg::frontend_state_type state_r;
	// Next value of the state
	frontend_pkg::frontend_state_type state_nxt;

	// Write strobes per register
	logic pri_ctrl_wr;
	logic aux_ctrl_wr;
	logic cur_ctrl_wr;
	// Read strobes with side effects
	logic pri_result_rd;
	logic aux_result_rd;

	// Channel fields of the incoming write
	frontend_pkg::pri_channel_type pri_channel_new;
	frontend_pkg::aux_channel_type aux_channel_new;

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Address match, used by every strobe decode
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
		return addr == offset;
	endfunction

	// Primary control readback word
	function automatic logic [31:0] pri_word(input frontend_pkg::frontend_state_type s);
		logic [31:0] w;
		w = 32'h00000000;
		w[`PRI_CH_MSB:`PRI_CH_LSB] = s.pri_channel; // RULE_14
		w[`PRI_RANGE_MSB:`PRI_RANGE_LSB] = s.pri_range;
		w[`PRI_UNI_BIT] = s.pri_unipolar;
		return w;
	endfunction

	// Auxiliary control readback word
	function automatic logic [31:0] aux_word(input frontend_pkg::frontend_state_type s);
		logic [31:0] w;
		w = 32'h00000000;
		w[`AUX_CH_MSB:`AUX_CH_LSB] = s.aux_channel;
		w[`AUX_UNI_BIT] = s.aux_unipolar;
		return w;
	endfunction

	// Current source readback word
	function automatic logic [31:0] cur_word(input frontend_pkg::frontend_state_type s);
		logic [31:0] w;
		w = 32'h00000000;
		w[`CUR_BURN_BIT] = s.burnout;
		w[`CUR_A_MSB:`CUR_A_LSB] = s.route_a;
		w[`CUR_B_MSB:`CUR_B_LSB] = s.route_b;
		return w;
	endfunction

	// ************************************************************
	// Strobe decode
	// ************************************************************

	// Writes and reads that touch a specific register
	always_comb begin
		pri_ctrl_wr = reg_write && hit(reg_addr, `PRI_CTRL_ADDR);
		aux_ctrl_wr = reg_write && hit(reg_addr, `AUX_CTRL_ADDR);
		cur_ctrl_wr = reg_write && hit(reg_addr, `CUR_CTRL_ADDR);
		pri_result_rd = reg_read && hit(reg_addr, `PRI_RESULT_ADDR);
		aux_result_rd = reg_read && hit(reg_addr, `AUX_RESULT_ADDR);
		// Channel fields as they would be written
		pri_channel_new = frontend_pkg::pri_channel_type'(reg_wdata[`PRI_CH_MSB:`PRI_CH_LSB]);
		aux_channel_new = frontend_pkg::aux_channel_type'(reg_wdata[`AUX_CH_MSB:`AUX_CH_LSB]);
	end

	// ************************************************************
	// Next state
	// ************************************************************

	// Control registers, restart pulses, sticky ready flags and read data
	always_comb begin
		state_nxt = state_r;
		// Restart pulses last one cycle
		state_nxt.pri_restart = 1'b0;
		state_nxt.aux_restart = 1'b0;

		// Primary control: channel, range and polarity
		if (pri_ctrl_wr) begin
			state_nxt.pri_channel = pri_channel_new; // RULE_01
			state_nxt.pri_range = frontend_pkg::gain_range_type'(
				reg_wdata[`PRI_RANGE_MSB:`PRI_RANGE_LSB]); // RULE_05
			state_nxt.pri_unipolar = reg_wdata[`PRI_UNI_BIT]; // RULE_07
			// Only a different pair restarts settling; polarity alone does not
			if (pri_channel_new != state_r.pri_channel) begin
				state_nxt.pri_restart = 1'b1; // RULE_03
			end
		end

		// Auxiliary control: channel and polarity, no gain field
		if (aux_ctrl_wr) begin
			state_nxt.aux_channel = aux_channel_new; // RULE_02
			state_nxt.aux_unipolar = reg_wdata[`AUX_UNI_BIT]; // RULE_06
			if (aux_channel_new != state_r.aux_channel) begin
				state_nxt.aux_restart = 1'b1; // RULE_03
			end
		end

		// Current source control: burnout and excitation steering
		if (cur_ctrl_wr) begin
			state_nxt.burnout = reg_wdata[`CUR_BURN_BIT]; // RULE_10
			state_nxt.route_a = frontend_pkg::exc_route_type'(
				reg_wdata[`CUR_A_MSB:`CUR_A_LSB]); // RULE_13
			state_nxt.route_b = frontend_pkg::exc_route_type'(
				reg_wdata[`CUR_B_MSB:`CUR_B_LSB]); // RULE_13
		end

		// Sticky ready flags: reading the result clears, a new result wins
		if (pri_result_rd) begin
			state_nxt.pri_ready = 1'b0;
		end
		if (pri_result_strobe) begin
			state_nxt.pri_ready = 1'b1;
		end
		if (aux_result_rd) begin
			state_nxt.aux_ready = 1'b0;
		end
		if (aux_result_strobe) begin
			state_nxt.aux_ready = 1'b1;
		end

		// Read data stands only in the cycle after the read strobe
		state_nxt.rdata = 32'h00000000;
		if (reg_read) begin
			unique case (reg_addr)
				// Primary control readback
				`PRI_CTRL_ADDR: begin
					state_nxt.rdata = pri_word(state_r);
				end
				// Auxiliary control readback
				`AUX_CTRL_ADDR: begin
					state_nxt.rdata = aux_word(state_r);
				end
				// Current source readback
				`CUR_CTRL_ADDR: begin
					state_nxt.rdata = cur_word(state_r);
				end
				// Settling and ready status
				`STATUS_ADDR: begin
					state_nxt.rdata[`ST_PRI_SETTLING_BIT] = pri_settling;
					state_nxt.rdata[`ST_AUX_SETTLING_BIT] = aux_settling;
					state_nxt.rdata[`ST_PRI_READY_BIT] = state_r.pri_ready;
					state_nxt.rdata[`ST_AUX_READY_BIT] = state_r.aux_ready;
				end
				// Latest primary result, low bits
				`PRI_RESULT_ADDR: begin
					state_nxt.rdata = 32'(pri_result);
				end
				// Latest auxiliary result, low bits
				`AUX_RESULT_ADDR: begin
					state_nxt.rdata = 32'(aux_result);
				end
				// Unmapped addresses read zero
				default: begin
					state_nxt.rdata = 32'h00000000;
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************

	// Reset puts burnout off, excitation off, pair 1/2, lowest range, bipolar
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r.pri_channel <= frontend_pkg::pri_channel_type'(
				`PRI_CTRL_RST & 6'h03);
			state_r.pri_range <= frontend_pkg::range_20mv;
			state_r.pri_unipolar <= 1'b0;
			state_r.aux_channel <= frontend_pkg::aux_channel_type'(
				`AUX_CTRL_RST & 3'h3);
			state_r.aux_unipolar <= 1'b0;
			state_r.burnout <= 1'b0;
			state_r.route_a <= frontend_pkg::route_off;
			state_r.route_b <= frontend_pkg::route_off;
			state_r.pri_restart <= 1'b0;
			state_r.aux_restart <= 1'b0;
			state_r.pri_ready <= 1'b0;
			state_r.aux_ready <= 1'b0;
			state_r.rdata <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ************************************************************
	// Result paths
	// ************************************************************

	// Primary path: averaging, settling hold-off and coding
	result_chop_coder #(
		.WIDTH(PRI_WIDTH),
		.SETTLE(`SETTLE_PERIODS)
	) pri_path (
		.clk(clk),
		.reset(reset),
		.restart(state_r.pri_restart),
		.unipolar(state_r.pri_unipolar),
		.sample_strobe(pri_sample_strobe),
		.sample(pri_sample),
		.result(pri_result),
		.result_strobe(pri_result_strobe),
		.settling(pri_settling)
	);

	// Auxiliary path: same treatment, fixed span
	result_chop_coder #(
		.WIDTH(AUX_WIDTH),
		.SETTLE(`SETTLE_PERIODS)
	) aux_path (
		.clk(clk),
		.reset(reset),
		.restart(state_r.aux_restart),
		.unipolar(state_r.aux_unipolar),
		.sample_strobe(aux_sample_strobe),
		.sample(aux_sample),
		.result(aux_result),
		.result_strobe(aux_result_strobe),
		.settling(aux_settling)
	);

	// ************************************************************
	// Current switches
	// ************************************************************

	// Burnout follows the selected primary pair through the mux outside
	current_switch_decoder currents (
		.clk(clk),
		.reset(reset),
		.burnout(state_r.burnout),
		.route_a(state_r.route_a),
		.route_b(state_r.route_b),
		.burn_src_on(burnout_source_on),
		.burn_snk_on(burnout_sink_on),
		.pin1_from_a(excitation_pin_1_from_a),
		.pin1_from_b(excitation_pin_1_from_b),
		.pin2_from_a(excitation_pin_2_from_a),
		.pin2_from_b(excitation_pin_2_from_b)
	);

	// ************************************************************
	// Outputs
	// ************************************************************

	// All driven straight from flip-flops
	assign reg_rdata = state_r.rdata;
	assign pri_channel_sel = state_r.pri_channel; // RULE_01
	assign pri_range_sel = state_r.pri_range; // RULE_05
	assign pri_unipolar = state_r.pri_unipolar;
	assign aux_channel_sel = state_r.aux_channel; // RULE_02
	assign aux_unipolar = state_r.aux_unipolar;

endmodule

/* dv/frontend_props.sv */
// Purpose: Port checks of the front end control.
// Assumes: Register map and latencies of the design.
// Notes: Bound into the top module.
`timescale 1ns/1ps
module frontend_props #(
	parameter int PRI_WIDTH = 24
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic pri_sample_strobe,
	input wire frontend_pkg::pri_channel_type pri_channel_sel,
	input wire frontend_pkg::gain_range_type pri_range_sel,
	input wire logic pri_unipolar,
	input wire frontend_pkg::aux_channel_type aux_channel_sel,
	input wire logic aux_unipolar,
	input wire logic burnout_source_on,
	input wire logic burnout_sink_on,
	input wire logic excitation_pin_1_from_a,
	input wire logic excitation_pin_1_from_b,
	input wire logic excitation_pin_2_from_a,
	input wire logic excitation_pin_2_from_b,
	input wire logic [PRI_WIDTH-1:0] pri_result,
	input wire logic pri_result_strobe,
	input wire logic pri_settling,
	input wire logic aux_settling
);
	// ************************************************************
	// Register port history
	// ************************************************************
	logic [31:0] wd_q; // Write data one edge back
	logic [31:0] wd_q2; // Write data two edges back
	logic cw_q; // Current write one edge back
	logic cw_q2; // Current write two edges back

	// Delay line of write data and current writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wd_q <= 32'h0;
			wd_q2 <= 32'h0;
			cw_q <= 1'b0;
			cw_q2 <= 1'b0;
		end else begin
			wd_q <= reg_wdata;
			wd_q2 <= wd_q;
			cw_q <= reg_write && reg_addr == 4'h2;
			cw_q2 <= cw_q;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ************************************************************
	// Assertions
	// ************************************************************
	pri_ctrl_write_a: assert property (reg_write && reg_addr == 4'h0 |=> pri_channel_sel == wd_q[1:0]
		&& pri_range_sel == wd_q[4:2] && pri_unipolar == wd_q[5]) else $error("primary select");
	aux_ctrl_write_a: assert property (reg_write && reg_addr == 4'h1 |=> aux_channel_sel == wd_q[1:0]
		&& aux_unipolar == wd_q[2]) else $error("aux select");
	burnout_pair_a: assert property (burnout_source_on == burnout_sink_on)
		else $error("burnout currents split");
	burnout_follow_a: assert property (cw_q2 && !cw_q |-> burnout_source_on == wd_q2[0])
		else $error("burnout not applied");
	route_a_steer_a: assert property (cw_q2 && !cw_q |-> excitation_pin_1_from_a == (wd_q2[2:1] == 2'h1)
		&& excitation_pin_2_from_a == (wd_q2[2:1] == 2'h2)) else $error("source A steering");
	route_b_steer_a: assert property (cw_q2 && !cw_q |-> excitation_pin_1_from_b == (wd_q2[4:3] == 2'h1)
		&& excitation_pin_2_from_b == (wd_q2[4:3] == 2'h2)) else $error("source B steering");
	read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("stray read data");
	unmapped_read_a: assert property (reg_read && reg_addr > 4'h5 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	status_read_a: assert property (reg_read && reg_addr == 4'h3
		|=> reg_rdata[1:0] == {$past(aux_settling), $past(pri_settling)}) else $error("status wrong");
	channel_settle_a: assert property (reg_write && reg_addr == 4'h0
		&& reg_wdata[1:0] != pri_channel_sel |-> ##[1:2] pri_settling) else $error("no settling");
	settled_result_a: assert property (pri_result_strobe |-> !pri_settling && $past(pri_sample_strobe))
		else $error("unsettled result");
	result_hold_a: assert property (!pri_result_strobe |-> $stable(pri_result))
		else $error("result moved");
endmodule

bind adc_input_frontend_control frontend_props #(.PRI_WIDTH(PRI_WIDTH)) props_i (.clk, .reset,
	.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pri_sample_strobe, .pri_channel_sel,
	.pri_range_sel, .pri_unipolar, .aux_channel_sel, .aux_unipolar, .burnout_source_on,
	.burnout_sink_on, .excitation_pin_1_from_a, .excitation_pin_1_from_b, .excitation_pin_2_from_a,
	.excitation_pin_2_from_b, .pri_result, .pri_result_strobe, .pri_settling, .aux_settling);

/* dv/transducer_model.sv */
// Purpose: Filter output words from a transducer on the selected input.
// Assumes: Two's complement words.
// Notes: The word line is inverted between strobes.
`timescale 1ns/1ps
module transducer_model #(
	parameter int WIDTH = 24
) (
	input wire logic clk,
	output logic strobe,
	output logic [WIDTH-1:0] sample
);
	// Quiet line at start
	initial begin
		strobe = 1'b0;
		sample = '0;
	end

	// One word after a gap of idle cycles
	task automatic emit(input logic [WIDTH-1:0] v, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		strobe <= 1'b1;
		sample <= v;
		@(posedge clk);
		strobe <= 1'b0;
		sample <= ~v;
	endtask
endmodule

/* dv/testbench.sv */
// Purpose: Self-checking bench of the front end control.
// Assumes: Register map, coding and latencies of the design.
// Notes: Expected codes come from the sample words.
`timescale 1ns/1ps
module testbench;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic pri_sample_strobe, aux_sample_strobe, pri_unipolar, aux_unipolar;
	logic [23:0] pri_sample, pri_result;
	logic [15:0] aux_sample, aux_result;
	frontend_pkg::pri_channel_type pri_channel_sel;
	frontend_pkg::gain_range_type pri_range_sel;
	frontend_pkg::aux_channel_type aux_channel_sel;
	logic burnout_source_on, burnout_sink_on, excitation_pin_1_from_a, excitation_pin_1_from_b;
	logic excitation_pin_2_from_a, excitation_pin_2_from_b;
	logic pri_result_strobe, pri_settling, aux_result_strobe, aux_settling;
	logic [23:0] prev [2]; // Last word per converter
	int errors = 0, checks_done = 0;
	logic [23:0] bip [6] = '{24'h000000, 24'h000000, 24'h800000, 24'h800000, 24'h7fffff, 24'h7fffff};
	logic [23:0] uni [6] = '{24'h7fffff, 24'h400000, 24'h400000, 24'h000000, 24'h000000, 24'hc00000};

	always #5 clk = ~clk;

	adc_input_frontend_control dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .pri_sample_strobe, .pri_sample, .aux_sample_strobe, .aux_sample,
		.pri_channel_sel, .pri_range_sel, .pri_unipolar, .aux_channel_sel, .aux_unipolar,
		.burnout_source_on, .burnout_sink_on, .excitation_pin_1_from_a, .excitation_pin_1_from_b,
		.excitation_pin_2_from_a, .excitation_pin_2_from_b, .pri_result, .pri_result_strobe,
		.pri_settling, .aux_result, .aux_result_strobe, .aux_settling);
	transducer_model pri_src (.clk, .strobe(pri_sample_strobe), .sample(pri_sample));
	transducer_model #(.WIDTH(16)) aux_src (.clk, .strobe(aux_sample_strobe), .sample(aux_sample));

	// ************************************************************
	// Tasks
	// ************************************************************
	// Verdict and end of run
	task complete_run;
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One comparison with case equality
	task check(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask

	// Write cycle; returns after the edge that takes it
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask

	// Read cycle; data checked while it stands
	task rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
	endtask

	// Coded average of two consecutive words of width w
	function automatic logic [23:0] code(input int w, input logic [23:0] a, b, input logic u);
		longint half, avg;
		half = longint'(1) << (w - 1);
		avg = ((a[w-1] ? longint'(a) - 2 * half : longint'(a))
			+ (b[w-1] ? longint'(b) - 2 * half : longint'(b))) >>> 1;
		if (!u) return 24'(avg + half);
		if (avg < 0) return 24'h0;
		if (avg == half - 1) return 24'(2 * half - 1);
		return 24'(avg * 2);
	endfunction

	// Sends one word; a fresh word gives no result
	task send(input logic aux, input logic [23:0] v, input logic u, fresh);
		logic [23:0] e;
		e = code(aux ? 16 : 24, prev[aux], v, u);
		if (aux) aux_src.emit(v[15:0], 2);
		else pri_src.emit(v, 0);
		#1;
		check("strobe", 32'(!fresh), 32'(aux ? aux_result_strobe : pri_result_strobe));
		if (!fresh) check("result", 32'(e), aux ? 32'(aux_result) : 32'(pri_result));
		prev[aux] = v;
	endtask

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(4'h0, 32'h0, "primary control");
		rd(4'h2, 32'h0, "current control");
		rd(4'h3, 32'h3, "status reset");
		foreach (bip[i]) send(1'b0, bip[i], 1'b0, i == 0);
		rd(4'h3, 32'h6, "status ready");
		rd(4'h4, 32'hffffff, "primary result");
		rd(4'h3, 32'h2, "status cleared");
		wr(4'h0, 32'h20);
		foreach (uni[i]) send(1'b0, uni[i], 1'b1, 1'b0);
		wr(4'h0, 32'h21);
		@(posedge clk);
		#1;
		check("settling", 32'h1, {31'h0, pri_settling});
		send(1'b0, 24'h100000, 1'b1, 1'b1);
		send(1'b0, 24'h100000, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, 32'(i * 5));
			check("primary select", 32'(i * 5),
				{26'h0, pri_unipolar, pri_range_sel, pri_channel_sel});
			rd(4'h0, 32'(i * 5), "primary readback");
			wr(4'h1, 32'(i));
			check("aux select", 32'(i), {29'h0, aux_unipolar, aux_channel_sel});
		end
		send(1'b1, 24'h008000, 1'b1, 1'b1);
		send(1'b1, 24'h007fff, 1'b1, 1'b0);
		send(1'b1, 24'h007fff, 1'b1, 1'b0);
		wr(4'h1, 32'h3);
		send(1'b1, 24'h000000, 1'b0, 1'b0);
		for (int i = 0; i < 32; i++) begin
			wr(4'h2, 32'(i));
			@(posedge clk);
			#1;
			check("switches", {26'h0, i[0], i[0], i[2:1] == 2'h1, i[4:3] == 2'h1, i[2:1] == 2'h2,
				i[4:3] == 2'h2}, {26'h0, burnout_source_on, burnout_sink_on, excitation_pin_1_from_a,
				excitation_pin_1_from_b, excitation_pin_2_from_a, excitation_pin_2_from_b});
		end
		wr(4'h2, 32'h0);
		wr(4'hf, 32'hffffffff);
		rd(4'hf, 32'h0, "unmapped read");
		rd(4'h0, 32'h23, "primary unchanged");
		complete_run;
	end
endmodule
